// ---- src/bpsf_top.sv ----
// burst preamble recogniser with clear-on-read start-id and rate/emphasis flags
//
// Overview of operation
// - start-id flag, status bit 0, sets when a start identifier is detected.
// - reading the status register returns the start-id flag, then clears it.
// - change flag, status bit 1, sets when rate code or pre-emphasis changes.
// - reading the status register clears the change flag; both reset to zero.
// - preamble is four 16-bit words: two sync words, burst info, length.
// - burst-info bits 0-4 give data type; 0 null, 3 pause, some reserved.
// - each data type except pause and the reserved codes has its burst repetition period in frames.
// - burst-info bit 7 marks a payload that may contain errors.
// - burst-info bits 8-12 are carried without fixed meaning.
`timescale 1ns/1ps
`default_nettype none
module bpsf_top #(
    parameter int TIMEOUT_FRAMES = bpsf_pkg::TIMEOUT_FRAMES
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              word_valid,
    input  wire logic [15:0]       word_data,
    input  wire logic              frame_tick,
    input  wire logic              start_id_seen,
    input  wire logic [3:0]        sample_rate_code,
    input  wire logic              preemphasis_flag,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_addr,
    output logic [7:0]             reg_rdata,
    output logic                   nonpcm_active,
    output logic                   burst_new,
    output bpsf_pkg::bpsf_pc_s     burst_info,
    output logic [15:0]            burst_length,
    output logic                   pause_detected,
    output logic                   null_detected
);

    localparam logic [12:0] GAP_LIMIT = 13'(TIMEOUT_FRAMES);

    bpsf_pkg::bpsf_regs_s   q_r;
    bpsf_pkg::bpsf_regs_s   q_nxt;
    bpsf_pkg::bpsf_pc_s     pc_dec;

    logic                   status_rd;
    logic                   rate_moved;

    bpsf_pc_decode u_pc_decode (
        .pc_word (q_r.pc_word),
        .pc_out  (pc_dec)
    );

    always_comb begin
        q_nxt      = q_r;
        status_rd  = reg_rd && (reg_addr == bpsf_pkg::ADDR_STATUS);
        rate_moved = q_r.seen && ((sample_rate_code != q_r.fs_prev)
                                  || (preemphasis_flag != q_r.pem_prev));

        // register read port: data captured before the clear takes effect
        if (status_rd) begin
            q_nxt.rdata                          = bpsf_pkg::STATUS_RESET;
            q_nxt.rdata[bpsf_pkg::BIT_START_ID]  = q_r.start_id;
            q_nxt.rdata[bpsf_pkg::BIT_RATE_CHG]  = q_r.rate_chg;
        end else if (reg_rd) begin
            q_nxt.rdata = bpsf_pkg::RDATA_UNMAPPED;
        end

        // set wins over the read clear
        q_nxt.start_id = (q_r.start_id && !status_rd) || start_id_seen;
        // change of rate code or emphasis sets flag
        q_nxt.rate_chg = (q_r.rate_chg && !status_rd) || rate_moved;

        // first clock after reset only loads the reference, so a strapped
        // nonzero rate does not raise a spurious change
        q_nxt.fs_prev  = sample_rate_code;
        q_nxt.pem_prev = preemphasis_flag;
        q_nxt.seen     = 1'b1;

        q_nxt.burst_new = 1'b0;

        if (frame_tick && q_r.nonpcm) begin
            if (q_r.gap_cnt >= GAP_LIMIT - bpsf_pkg::GAP_ONE) begin
                q_nxt.nonpcm  = 1'b0;
                q_nxt.gap_cnt = bpsf_pkg::GAP_ZERO;
            end else begin
                q_nxt.gap_cnt = q_r.gap_cnt + bpsf_pkg::GAP_ONE;
            end
        end

        if (word_valid) begin
            case (q_r.state)
                bpsf_pkg::ST_PA: begin
                    if (word_data == bpsf_pkg::SYNC_WORD_A) begin
                        q_nxt.state = bpsf_pkg::ST_PB;
                    end
                end
                bpsf_pkg::ST_PB: begin
                    // a repeated first sync word keeps the hunt aligned
                    if (word_data == bpsf_pkg::SYNC_WORD_B) begin
                        q_nxt.state = bpsf_pkg::ST_PC;
                    end else if (word_data != bpsf_pkg::SYNC_WORD_A) begin
                        q_nxt.state = bpsf_pkg::ST_PA;
                    end
                end
                bpsf_pkg::ST_PC: begin
                    // reserved bits kept as received, not checked
                    // stream number kept as received, not checked
                    q_nxt.pc_word = word_data;
                    q_nxt.state   = bpsf_pkg::ST_PD;
                end
                bpsf_pkg::ST_PD: begin
                    q_nxt.length_bits = word_data;
                    q_nxt.pc          = pc_dec;
                    q_nxt.burst_new   = 1'b1;
                    q_nxt.nonpcm      = 1'b1;
                    q_nxt.gap_cnt     = bpsf_pkg::GAP_ZERO;
                    q_nxt.state       = bpsf_pkg::ST_PA;
                end
                default: begin
                    q_nxt.state = bpsf_pkg::ST_PA;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    always_comb begin
        reg_rdata      = q_r.rdata;
        nonpcm_active  = q_r.nonpcm;
        burst_new      = q_r.burst_new;
        burst_info     = q_r.pc;
        burst_length   = q_r.length_bits;
        pause_detected = q_r.nonpcm && (q_r.pc.data_type == bpsf_pkg::TYPE_PAUSE);
        null_detected  = q_r.nonpcm && (q_r.pc.data_type == bpsf_pkg::TYPE_NULL);
    end

endmodule : bpsf_top
`default_nettype wire

// ---- inc/bpsf_pkg.sv ----
// constants, state encodings and carriers for the burst preamble / status flag block
package bpsf_pkg;

    // status register map
    localparam logic [7:0]  ADDR_STATUS     = 8'h26;
    localparam int          BIT_START_ID    = 0;
    localparam int          BIT_RATE_CHG    = 1;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
    localparam logic [7:0]  RDATA_UNMAPPED  = 8'h00;

    // preamble sync words
    localparam logic [15:0] SYNC_WORD_A     = 16'hF872;
    localparam logic [15:0] SYNC_WORD_B     = 16'h4E1F;

    // burst-info field positions
    localparam int          PC_TYPE_LSB     = 0;
    localparam int          PC_TYPE_MSB     = 4;
    localparam int          PC_ERR_BIT      = 7;
    localparam int          PC_INFO_LSB     = 8;
    localparam int          PC_INFO_MSB     = 12;

    // data-type codes
    localparam logic [4:0]  TYPE_NULL       = 5'h00;
    localparam logic [4:0]  TYPE_RSV_A      = 5'h02;
    localparam logic [4:0]  TYPE_PAUSE      = 5'h03;
    localparam logic [4:0]  TYPE_RSV_B      = 5'h0A;
    localparam logic [4:0]  TYPE_RSV_HI     = 5'h10;

    // burst repetition periods in frames
    localparam logic [12:0] PER_NONE        = 13'h0000;
    localparam logic [12:0] PER_384         = 13'h0180;
    localparam logic [12:0] PER_512         = 13'h0200;
    localparam logic [12:0] PER_1024        = 13'h0400;
    localparam logic [12:0] PER_1152        = 13'h0480;
    localparam logic [12:0] PER_1536        = 13'h0600;
    localparam logic [12:0] PER_2048        = 13'h0800;
    localparam logic [12:0] PER_NULL_MAX    = 13'h1000;

    // frames without a preamble before non-pcm indication ends
    localparam int          TIMEOUT_FRAMES  = 4096;
    localparam logic [12:0] GAP_ZERO        = 13'h0000;
    localparam logic [12:0] GAP_ONE         = 13'h0001;

    typedef enum logic [1:0] {
        ST_PA = 2'b00,
        ST_PB = 2'b01,
        ST_PC = 2'b11,
        ST_PD = 2'b10
    } bpsf_state_e;

    typedef struct packed {
        logic [4:0]  data_type;
        logic        payload_err;
        logic [4:0]  type_info;
        logic [12:0] period;
        logic        reserved_type;
    } bpsf_pc_s;

    typedef struct packed {
        bpsf_state_e state;
        logic [15:0] pc_word;
        bpsf_pc_s    pc;
        logic [15:0] length_bits;
        logic        nonpcm;
        logic [12:0] gap_cnt;
        logic        burst_new;
        logic        start_id;
        logic        rate_chg;
        logic [3:0]  fs_prev;
        logic        pem_prev;
        logic        seen;
        logic [7:0]  rdata;
    } bpsf_regs_s;

endpackage : bpsf_pkg

// ---- src/bpsf_pc_decode.sv ----
// burst-info word decoder: data type, error flag, dependent info, period
`timescale 1ns/1ps
`default_nettype none
module bpsf_pc_decode (
    input  wire logic [15:0]       pc_word,
    output bpsf_pkg::bpsf_pc_s     pc_out
);

    function automatic logic [12:0] bpsf_period(input logic [4:0] code);
        case (code)
            5'h00:                      bpsf_period = bpsf_pkg::PER_NULL_MAX;
            5'h01:                      bpsf_period = bpsf_pkg::PER_1536;
            5'h04, 5'h08:               bpsf_period = bpsf_pkg::PER_384;
            5'h05, 5'h06, 5'h09:        bpsf_period = bpsf_pkg::PER_1152;
            5'h07, 5'h0C, 5'h0F:        bpsf_period = bpsf_pkg::PER_1024;
            5'h0B, 5'h0E:               bpsf_period = bpsf_pkg::PER_512;
            5'h0D:                      bpsf_period = bpsf_pkg::PER_2048;
            // pause and reserved codes carry no fixed period
            default:                    bpsf_period = bpsf_pkg::PER_NONE;
        endcase
    endfunction : bpsf_period

    logic [4:0] code;

    always_comb begin
        code                 = pc_word[bpsf_pkg::PC_TYPE_MSB:bpsf_pkg::PC_TYPE_LSB];
        pc_out.data_type     = code;
        pc_out.reserved_type = (code == bpsf_pkg::TYPE_RSV_A) || (code == bpsf_pkg::TYPE_RSV_B)
                               || (code >= bpsf_pkg::TYPE_RSV_HI);
        pc_out.payload_err   = pc_word[bpsf_pkg::PC_ERR_BIT];
        pc_out.type_info     = pc_word[bpsf_pkg::PC_INFO_MSB:bpsf_pkg::PC_INFO_LSB];
        pc_out.period        = bpsf_period(code);
    end

endmodule : bpsf_pc_decode
`default_nettype wire

// ---- tb/bpsf_properties.sv ----
// bound checker for the burst preamble and status flag block
`timescale 1ns/1ps
`default_nettype none
module bpsf_properties (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               word_valid,
    input wire logic [15:0]        word_data,
    input wire logic               start_id_seen,
    input wire logic               reg_rd,
    input wire logic [7:0]         reg_addr,
    input wire logic [7:0]         reg_rdata,
    input wire logic               burst_new,
    input wire bpsf_pkg::bpsf_pc_s burst_info
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    start_set_a: assert property (start_id_seen
        ##1 (reg_rd && reg_addr == 8'h26) |=> reg_rdata[0]) else $error("start flag lost");
    start_clr_a: assert property (reg_rd && reg_addr == 8'h26 && !start_id_seen
        ##1 reg_rd |=> !reg_rdata[0]) else $error("start flag kept");
    rsv_zero_a: assert property (reg_rd |=> reg_rdata[7:2] == 6'h00)
        else $error("spare bits set");
    unmapped_read_a: assert property (reg_rd && reg_addr != 8'h26
        |=> reg_rdata == 8'h00) else $error("unmapped read");
    burst_pulse_a: assert property (word_valid && word_data == 16'hF872
        ##1 word_valid && word_data == 16'h4E1F ##1 word_valid[*2] |=> burst_new)
        else $error("burst missed");
    burst_once_a: assert property (burst_new |=> !burst_new)
        else $error("burst pulse long");
    err_carry_a: assert property (word_valid[*2] ##1 burst_new
        |-> burst_info.payload_err == $past(word_data[7], 2)) else $error("error flag");
    info_carry_a: assert property (word_valid[*2] ##1 burst_new |->
        burst_info.type_info == $past(word_data[12:8], 2)) else $error("type info");
endmodule : bpsf_properties
bind bpsf_top bpsf_properties chk (
    .clk           (clk),
    .rst_n         (rst_n),
    .word_valid    (word_valid),
    .word_data     (word_data),
    .start_id_seen (start_id_seen),
    .reg_rd        (reg_rd),
    .reg_addr      (reg_addr),
    .reg_rdata     (reg_rdata),
    .burst_new     (burst_new),
    .burst_info    (burst_info)
);
`default_nettype wire

// ---- tb/bpsf_stream_src.sv ----
// stream source model: sends four-word burst preambles
`timescale 1ns/1ps
`default_nettype none
module bpsf_stream_src (
    input  wire logic       clk,
    output var logic        word_valid = 1'b0,
    output var logic [15:0] word_data = 16'h0000
);
    task send(input logic [4:0] ty, input logic er, input logic [4:0] inf, input logic [15:0] len);
        logic [15:0] w [4];
        w = '{bpsf_pkg::SYNC_WORD_A, bpsf_pkg::SYNC_WORD_B, {3'h0, inf, er, 2'h0, ty}, len};
        word_valid = 1'b1;
        for (int i = 0; i < 4; i++) begin
            word_data = w[i];
            @(posedge clk) #1;
        end
        // idle line must not look like a held word
        word_valid = 1'b0;
        word_data = ~word_data;
    endtask : send
endmodule : bpsf_stream_src
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the burst preamble and status flag block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst_n = 1'b0, frame_tick = 1'b0, start_id_seen = 1'b0;
    logic preemphasis_flag = 1'b0, reg_rd = 1'b0, word_valid, burst_new, nonpcm_active;
    logic pause_detected, null_detected;
    logic [3:0] sample_rate_code = 4'h2;
    logic [7:0] reg_addr = 8'h00, reg_rdata;
    logic [15:0] word_data, burst_length;
    bpsf_pkg::bpsf_pc_s burst_info;
    int failures = 0, tests_run = 0;
    localparam logic [12:0] per_tbl [16] = '{13'h1000, 13'h0600, 13'h0000, 13'h0000, 13'h0180,
        13'h0480, 13'h0480, 13'h0400, 13'h0180, 13'h0480, 13'h0000, 13'h0200, 13'h0400,
        13'h0800, 13'h0200, 13'h0400};
    bpsf_stream_src src (
        .clk        (clk),
        .word_valid (word_valid),
        .word_data  (word_data)
    );
    bpsf_top #(.TIMEOUT_FRAMES(8)) uut (
        .clk              (clk),
        .rst_n            (rst_n),
        .word_valid       (word_valid),
        .word_data        (word_data),
        .frame_tick       (frame_tick),
        .start_id_seen    (start_id_seen),
        .sample_rate_code (sample_rate_code),
        .preemphasis_flag (preemphasis_flag),
        .reg_rd           (reg_rd),
        .reg_addr         (reg_addr),
        .reg_rdata        (reg_rdata),
        .nonpcm_active    (nonpcm_active),
        .burst_new        (burst_new),
        .burst_info       (burst_info),
        .burst_length     (burst_length),
        .pause_detected   (pause_detected),
        .null_detected    (null_detected)
    );
    initial forever #10 clk = ~clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        failures += int'(got !== exp);
    endtask : chk
    task rd(input logic [7:0] a, input logic [7:0] e);
        {reg_rd, reg_addr} = {1'b1, a};
        @(posedge clk) #1;
        chk(reg_rdata, e);
    endtask : rd
    task report_and_stop;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    // set beats the clearing read; strobe stays up, reads run back to back
    task t_status;
        start_id_seen = 1'b1;
        rd(8'h26, 8'h00);
        start_id_seen = 1'b0;
        rd(8'h26, 8'h01);
        rd(8'h26, 8'h00);
        sample_rate_code = 4'hA;
        rd(8'h25, 8'h00);
        rd(8'h26, 8'h02);
        preemphasis_flag = 1'b1;
        rd(8'h25, 8'h00);
        rd(8'h26, 8'h02);
        rd(8'h26, 8'h00);
        reg_rd = 1'b0;
    endtask : t_status
    task t_types;
        logic [4:0] c;
        bpsf_pkg::bpsf_pc_s e;
        for (int i = 0; i < 17; i++) begin
            c = 5'(i);
            src.send(c, c[0], ~c, {c, 11'h2A5});
            e = {c, c[0], ~c, (c[4] ? 13'h0000 : per_tbl[c[3:0]]), c[4] || c == 5'h02 || c == 5'h0A};
            chk(burst_new, 1'b1);
            chk(nonpcm_active, 1'b1);
            chk(burst_info, e);
            chk(burst_length, {c, 11'h2A5});
            chk({pause_detected, null_detected}, {c == 5'h03, c == 5'h00});
            @(posedge clk) #1;
        end
    endtask : t_types
    task t_timeout;
        frame_tick = 1'b1;
        for (int i = 1; i <= 8; i++) begin
            @(posedge clk) #1;
            chk(nonpcm_active, 32'(i < 8));
        end
        frame_tick = 1'b0;
    endtask : t_timeout
    initial begin
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1 t_status;
        t_types;
        t_timeout;
        report_and_stop;
    end
endmodule : tb
`default_nettype wire
